// ---- src/tmr2_core.sv ----
`timescale 1ns/1ps
module tmr2_core
  import tmr2_pkg::*;
(
  input wire logic ref_clk, // 10 MHz oscillator
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic gate_count_pin, // Gate or event input
  input wire logic reload_trigger_pin, // Reload trigger input
  input wire logic [3:0] capture_pin, // Capture inputs
  output logic [3:0] compare_out, // Compare output pins
  output logic irq // Level interrupt
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt; // Control fields
  logic [15:0] count_r, count_nxt; // Timer count
  logic [15:0] reload_r, reload_nxt; // Reload value
  logic [TMR2_ST_W-1:0] stat_r, stat_nxt; // Sticky events
  logic [TMR2_ST_W-1:0] mask_r, mask_nxt; // Interrupt enables
  logic [3:0] shadow_r, shadow_nxt; // Mode 1 shadow latches
  logic [3:0] port_r, port_nxt; // Port latches
  logic [7:0] ccmode_r, ccmode_nxt; // Per channel mode
  logic [15:0] cc_r [TMR2_NUM_CH]; // Compare/capture words
  logic [15:0] cc_nxt [TMR2_NUM_CH];
  logic [2:0] mc_r, mc_nxt; // Oscillator phase in cycle
  logic half_r, half_nxt; // Prescale /12 toggle
  logic gate_q_r, gate_q_nxt; // Last sample of gate pin
  logic trig_q_r, trig_q_nxt; // Last sample of trigger pin
  logic [3:0] capq_r, capq_nxt; // Last samples of capture pins
  logic [31:0] rdata_r, rdata_nxt; // Read data
  logic wait_r, wait_nxt; // Waitrequest
  logic irq_r, irq_nxt; // Interrupt
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merge write data into a word under byte enables
  function automatic logic [15:0] tmr2_merge(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction
  // Falling edge between two machine cycle samples
  function automatic logic tmr2_fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction
  logic mc_tick; // End of a machine cycle
  logic acc_go; // Access taken this edge
  logic wr_go;
  logic rd_go;
  logic rd_cap; // Read seen while stalled
  tmr2_func_t func;
  assign mc_tick = (mc_r == TMR2_MC_LAST);
  assign acc_go = (avs_read | avs_write) & ~wait_r;
  assign wr_go = avs_write & ~wait_r;
  assign rd_go = avs_read & ~wait_r;
  // Read seen while stalled: fetch the answer one edge early
  assign rd_cap = avs_read & wait_r;
  assign func = tmr2_func_t'(ctrl_r[TMR2_FUNC_LSB +: 2]);
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Counting, reload, compare, capture and register access
  always_comb begin
    logic inc;
    logic ovf;
    logic trig_fall;
    logic [TMR2_ST_W-1:0] ev;
    logic [3:0] match;
    tmr2_ccmode_t md;
    inc = 1'b0;
    ovf = 1'b0;
    trig_fall = 1'b0;
    ev = '0;
    match = '0;
    md = TMR2_CC_OFF;
    ctrl_nxt = ctrl_r;
    count_nxt = count_r;
    reload_nxt = reload_r;
    mask_nxt = mask_r;
    shadow_nxt = shadow_r;
    port_nxt = port_r;
    ccmode_nxt = ccmode_r;
    cc_nxt = cc_r;
    gate_q_nxt = gate_q_r;
    trig_q_nxt = trig_q_r;
    capq_nxt = capq_r;
    half_nxt = half_r;
    rdata_nxt = rdata_r;
    mc_nxt = mc_tick ? 3'h0 : 3'(mc_r + 3'h1);
    // Pins are sampled once per machine cycle
    if (mc_tick) begin
      gate_q_nxt = gate_count_pin;
      trig_q_nxt = reload_trigger_pin;
      capq_nxt = capture_pin;
      half_nxt = ~half_r;
      unique case (func)
        TMR2_FN_STOP: inc = 1'b0;
        TMR2_FN_TIMER: inc = ~ctrl_r[TMR2_PRESC_BIT] | half_r;
        TMR2_FN_GATED: begin
          inc = gate_count_pin & (~ctrl_r[TMR2_PRESC_BIT] | half_r);
        end
        TMR2_FN_EVENT: inc = tmr2_fall(gate_q_r, gate_count_pin);
      endcase
      trig_fall = tmr2_fall(trig_q_r, reload_trigger_pin);
    end
    // Count advance and rollover
    if (inc) begin
      count_nxt = 16'(count_r + 16'h0001);
      ovf = (count_r == 16'hFFFF);
      if (ovf && ctrl_r[TMR2_RLD_EN_BIT] && !ctrl_r[TMR2_RLD_MODE_BIT]) begin
        count_nxt = reload_r;
      end
    end
    if (trig_fall && ctrl_r[TMR2_RLD_EN_BIT] && ctrl_r[TMR2_RLD_MODE_BIT]) begin
      count_nxt = reload_r;
    end
    ev[TMR2_ST_OVF] = ovf;
    ev[TMR2_ST_EXT] = trig_fall & ctrl_r[TMR2_EXT_EN_BIT];
    // Per channel compare and capture
    for (int i = 0; i < TMR2_NUM_CH; i++) begin
      md = tmr2_ccmode_t'(ccmode_r[2*i +: 2]);
      match[i] = inc && (count_nxt == cc_r[i]);
      unique case (md)
        TMR2_CC_CMP0: begin
          if (match[i]) begin
            port_nxt[i] = 1'b1;
          end else if (ovf) begin
            port_nxt[i] = 1'b0;
          end
        end
        TMR2_CC_CMP1: begin
          if (match[i]) begin
            port_nxt[i] = shadow_r[i];
          end
        end
        TMR2_CC_CAPT: begin
          match[i] = mc_tick && tmr2_fall(capq_r[i], capture_pin[i]);
          if (match[i]) begin
            cc_nxt[i] = count_r;
          end
        end
        TMR2_CC_OFF: match[i] = 1'b0;
      endcase
    end
    ev[TMR2_ST_CM0 +: TMR2_NUM_CH] = match;
    // Register writes
    if (wr_go) begin
      unique case (avs_address)
        TMR2_CTRL_OFS: begin
          if (avs_byteenable[0]) begin
            ctrl_nxt = avs_writedata[7:0];
          end
        end
        TMR2_COUNT_OFS: count_nxt = tmr2_merge(count_r, avs_writedata,
            avs_byteenable);
        TMR2_RELOAD_OFS: reload_nxt = tmr2_merge(reload_r, avs_writedata,
            avs_byteenable);
        TMR2_MASK_OFS: begin
          if (avs_byteenable[0]) begin
            mask_nxt = avs_writedata[TMR2_ST_W-1:0];
          end
        end
        TMR2_PORT_OFS: begin
          for (int i = 0; i < TMR2_NUM_CH; i++) begin
            // Mode 0 owns the latch; mode 1 writes the shadow
            if (avs_byteenable[0] && ccmode_r[2*i +: 2] == TMR2_CC_CMP1) begin
              shadow_nxt[i] = avs_writedata[i];
            end else if (avs_byteenable[0] &&
                ccmode_r[2*i +: 2] != TMR2_CC_CMP0) begin
              port_nxt[i] = avs_writedata[i];
            end
          end
        end
        TMR2_CCMODE_OFS: begin
          if (avs_byteenable[0]) begin
            ccmode_nxt = avs_writedata[7:0];
          end
        end
        default: begin
          for (int i = 0; i < TMR2_NUM_CH; i++) begin
            if (avs_address == 6'(TMR2_CC0_OFS + 6'(4*i))) begin
              cc_nxt[i] = tmr2_merge(cc_r[i], avs_writedata, avs_byteenable);
            end
          end
        end
      endcase
    end
    // Register reads; unmapped reads return zero. The word is latched
    // on the stall cycle and stands at the edge that completes the read
    if (rd_cap) begin
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address)
        TMR2_CTRL_OFS: rdata_nxt[7:0] = ctrl_r;
        TMR2_COUNT_OFS: rdata_nxt[15:0] = count_r;
        TMR2_RELOAD_OFS: rdata_nxt[15:0] = reload_r;
        TMR2_STAT_OFS: rdata_nxt[TMR2_ST_W-1:0] = stat_r;
        TMR2_MASK_OFS: rdata_nxt[TMR2_ST_W-1:0] = mask_r;
        TMR2_PORT_OFS: rdata_nxt[7:0] = {shadow_r, port_r};
        TMR2_CCMODE_OFS: rdata_nxt[7:0] = ccmode_r;
        default: begin
          for (int i = 0; i < TMR2_NUM_CH; i++) begin
            if (avs_address == 6'(TMR2_CC0_OFS + 6'(4*i))) begin
              rdata_nxt[15:0] = cc_r[i];
            end
          end
        end
      endcase
    end
    // Sticky status: a read clears only the bits it reported, so an
    // event landing in the stall cycle is kept for the next read;
    // a new event wins over the clear
    stat_nxt = stat_r;
    if (rd_go && avs_address == TMR2_STAT_OFS) begin
      stat_nxt = stat_r & ~rdata_r[TMR2_ST_W-1:0];
    end
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
    // One wait cycle per access, then release
    // Request seen while stalled drops waitrequest for the next edge
    wait_nxt = ~acc_go & (avs_read | avs_write) ? 1'b0 : 1'b1;
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Register all state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= TMR2_CTRL_RST;
      count_r <= TMR2_WORD_RST;
      reload_r <= TMR2_WORD_RST;
      stat_r <= '0;
      mask_r <= '0;
      shadow_r <= '0;
      port_r <= '0;
      ccmode_r <= '0;
      for (int i = 0; i < TMR2_NUM_CH; i++) begin
        cc_r[i] <= TMR2_WORD_RST;
      end
      mc_r <= 3'h0;
      half_r <= 1'b0;
      gate_q_r <= 1'b0;
      trig_q_r <= 1'b0;
      capq_r <= '0;
      rdata_r <= 32'h0000_0000;
      wait_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      count_r <= count_nxt;
      reload_r <= reload_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      shadow_r <= shadow_nxt;
      port_r <= port_nxt;
      ccmode_r <= ccmode_nxt;
      cc_r <= cc_nxt;
      mc_r <= mc_nxt;
      half_r <= half_nxt;
      gate_q_r <= gate_q_nxt;
      trig_q_r <= trig_q_nxt;
      capq_r <= capq_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign compare_out = port_r;
  assign irq = irq_r;
endmodule

// ---- shared/tmr2_pkg.sv ----
package tmr2_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses, word aligned)
  // ----------------------------------------------------------------
  localparam logic [5:0] TMR2_CTRL_OFS = 6'h00;
  localparam logic [5:0] TMR2_COUNT_OFS = 6'h04;
  localparam logic [5:0] TMR2_RELOAD_OFS = 6'h08;
  localparam logic [5:0] TMR2_STAT_OFS = 6'h0C;
  localparam logic [5:0] TMR2_MASK_OFS = 6'h10;
  localparam logic [5:0] TMR2_PORT_OFS = 6'h14;
  localparam logic [5:0] TMR2_CCMODE_OFS = 6'h18;
  localparam logic [5:0] TMR2_CC0_OFS = 6'h20;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int TMR2_FUNC_LSB = 0;
  localparam int TMR2_PRESC_BIT = 2;
  localparam int TMR2_RLD_EN_BIT = 3;
  localparam int TMR2_RLD_MODE_BIT = 4;
  localparam int TMR2_EXT_EN_BIT = 5;
  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int TMR2_ST_OVF = 0;
  localparam int TMR2_ST_EXT = 1;
  localparam int TMR2_ST_CM0 = 2;
  localparam int TMR2_NUM_CH = 4;
  localparam int TMR2_ST_W = 6;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR2_CTRL_RST = 8'h00;
  localparam logic [15:0] TMR2_WORD_RST = 16'h0000;
  localparam int TMR2_OSC_PER_MC = 6;
  localparam logic [2:0] TMR2_MC_LAST = 3'(TMR2_OSC_PER_MC - 1);
  // Channel modes
  typedef enum logic [1:0] {
    TMR2_CC_OFF = 2'h0,
    TMR2_CC_CMP0 = 2'h1,
    TMR2_CC_CMP1 = 2'h2,
    TMR2_CC_CAPT = 2'h3
  } tmr2_ccmode_t;
  // Timer function
  typedef enum logic [1:0] {
    TMR2_FN_STOP = 2'h0,
    TMR2_FN_TIMER = 2'h1,
    TMR2_FN_EVENT = 2'h2,
    TMR2_FN_GATED = 2'h3
  } tmr2_func_t;
endpackage

// ---- dv/tmr2_chk_props.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bus handshake and output checks
// ----------------------------------------
module tmr2_chk
  import tmr2_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [5:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic gate_count_pin, // Gate pin
  input wire logic reload_trigger_pin, // Trigger pin
  input wire logic [3:0] capture_pin, // Capture pins
  input wire logic [3:0] compare_out, // Compare pins
  input wire logic irq // Interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Stall, one ready cycle, stall again
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_read_wait: assert property ($rose(avs_read) |-> s_one_wait)
    else $error("read did not end after one wait");
  chk_write_wait: assert property
    ((avs_write && avs_waitrequest) |=> !avs_waitrequest)
    else $error("write not answered next cycle");
  chk_low_once: assert property
    ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("ready held longer than one cycle");
  chk_low_cause: assert property
    (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("ready without a request");
  chk_rdata_hold: assert property
    ($changed(avs_readdata) |-> !avs_waitrequest && avs_read)
    else $error("read data moved outside a read");
  chk_unmapped_zero: assert property
    ((avs_read && !avs_waitrequest &&
     (avs_address > 6'h2C || avs_address == 6'h1C)) |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> compare_out == 4'h0 && !irq && avs_waitrequest)
    else $error("outputs not quiet after reset");
  chk_mask_off: assert property
    ((avs_write && !avs_waitrequest && avs_address == TMR2_MASK_OFS &&
     avs_byteenable[0] && avs_writedata[5:0] == 6'h00) |-> ##2 !irq)
    else $error("interrupt stayed up with mask cleared");
endmodule
bind tmr2_core tmr2_chk u_chk (.ref_clk, .sys_rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .gate_count_pin, .reload_trigger_pin, .capture_pin,
  .compare_out, .irq);

// ---- dv/tmr2_pin_mdl.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// External pin source
// ----------------------------------------
module tmr2_pin_mdl (
  input wire logic ref_clk, // Clock
  output logic gate_count_pin, // Gate or event line
  output logic reload_trigger_pin, // Reload trigger line
  output logic [3:0] capture_pin // Capture lines
);
  // Lines idle high, like pulled-up port pins
  initial begin
    gate_count_pin = 1'b1;
    reload_trigger_pin = 1'b1;
    capture_pin = 4'hF;
  end
  // Steady gate level
  task automatic set_gate(input logic lvl);
    gate_count_pin <= lvl;
  endtask
  // Event pulses, each level held two machine cycles
  task automatic events(input int n);
    repeat (n) begin
      gate_count_pin <= 1'b0;
      repeat (12) @(posedge ref_clk);
      gate_count_pin <= 1'b1;
      repeat (12) @(posedge ref_clk);
    end
  endtask
  // One falling edge on the trigger line
  task automatic trig();
    reload_trigger_pin <= 1'b0;
    repeat (12) @(posedge ref_clk);
    reload_trigger_pin <= 1'b1;
    repeat (12) @(posedge ref_clk);
  endtask
  // One falling edge on one capture line
  task automatic cap(input int ch);
    capture_pin <= ~(4'h1 << ch);
    repeat (12) @(posedge ref_clk);
    capture_pin <= 4'hF;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule

// ---- dv/timer2_compare_reload_tb.sv ----
`timescale 1ns/1ps
module timer2_compare_reload_tb;
  import tmr2_pkg::*;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic ref_clk = 1'b0; // Clock
  logic sys_rst = 1'b1; // Reset
  logic [5:0] avs_address = 6'h00; // Address
  logic avs_read = 1'b0; // Read
  logic avs_write = 1'b0; // Write
  logic [31:0] avs_writedata = 32'h0; // Write data
  logic [3:0] avs_byteenable = 4'hF; // Byte lanes
  logic [31:0] avs_readdata; // Read data
  logic avs_waitrequest; // Stall
  logic gate_count_pin; // Gate or event line
  logic reload_trigger_pin; // Trigger line
  logic [3:0] capture_pin; // Capture lines
  logic [3:0] compare_out; // Compare pins
  logic irq; // Interrupt
  logic [31:0] rdv; // Last read value
  int bad_count = 0; // Mismatches
  int checks = 0; // Comparisons
  int cyc = 0; // Elapsed clocks
  tmr2_core uut (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .gate_count_pin, .reload_trigger_pin, .capture_pin, .compare_out, .irq);
  tmr2_pin_mdl pins (.ref_clk, .gate_count_pin, .reload_trigger_pin,
    .capture_pin);
  // Clock
  initial forever #50 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [5:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] lo, hi, got, input string nm);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      bad_count++;
      $display("unexpected %s: expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] lo, hi,
                    input string nm);
    rd(a);
    chk(lo, hi, rdv, nm);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    tick(5);
    sys_rst <= 1'b0;
    rc(TMR2_CTRL_OFS, 32'h0, 32'h0, "ctrl");
    rc(6'h3C, 32'h0, 32'h0, "unmapped");
    // Free timer at each prescale
    for (int p = 0; p < 2; p++) begin
      wr(TMR2_COUNT_OFS, 32'h0);
      wr(TMR2_CTRL_OFS, 32'h1 | (p << 2));
      tick(120);
      rc(TMR2_COUNT_OFS, 32'h13 >> p, 32'h18 >> p, "timer");
    end
    // Lane 0 alone leaves the high byte of a word alone
    wr(TMR2_RELOAD_OFS, 32'hFFFF);
    avs_byteenable <= 4'h1;
    wr(TMR2_RELOAD_OFS, 32'h0012);
    avs_byteenable <= 4'hF;
    rc(TMR2_RELOAD_OFS, 32'hFF12, 32'hFF12, "lane 0");
    // Overflow with reload and interrupt
    wr(TMR2_CTRL_OFS, 32'h0);
    wr(TMR2_RELOAD_OFS, 32'hFF00);
    wr(TMR2_COUNT_OFS, 32'hFFFE);
    wr(TMR2_MASK_OFS, 32'h1);
    wr(TMR2_CTRL_OFS, 32'h9);
    tick(30);
    wr(TMR2_CTRL_OFS, 32'h0);
    rc(TMR2_COUNT_OFS, 32'hFF00, 32'hFF08, "reload");
    chk(32'h1, 32'h1, irq, "irq");
    rc(TMR2_STAT_OFS, 32'h1, 32'h1, "overflow");
    tick(1);
    chk(32'h0, 32'h0, irq, "irq clear");
    rc(TMR2_STAT_OFS, 32'h0, 32'h0, "stat clear");
    wr(TMR2_MASK_OFS, 32'h0);
    // Gated timer
    pins.set_gate(1'b0);
    wr(TMR2_COUNT_OFS, 32'h0);
    wr(TMR2_CTRL_OFS, 32'h3);
    tick(60);
    rc(TMR2_COUNT_OFS, 32'h0, 32'h0, "gate low");
    pins.set_gate(1'b1);
    tick(60);
    rc(TMR2_COUNT_OFS, 32'h8, 32'hC, "gate high");
    // Event counter
    wr(TMR2_CTRL_OFS, 32'h0);
    wr(TMR2_COUNT_OFS, 32'h0);
    wr(TMR2_CTRL_OFS, 32'h2);
    pins.events(5);
    tick(12);
    rc(TMR2_COUNT_OFS, 32'h5, 32'h5, "events");
    // Trigger reload, flag off then on
    wr(TMR2_RELOAD_OFS, 32'h1234);
    for (int e = 0; e < 2; e++) begin
      wr(TMR2_COUNT_OFS, 32'h0);
      wr(TMR2_CTRL_OFS, 32'h1A | (e << 5));
      pins.trig();
      rc(TMR2_COUNT_OFS, 32'h1234, 32'h1234, "trig reload");
      rc(TMR2_STAT_OFS, e << 1, e << 1, "ext flag");
    end
    // Compare modes: ch0 direct, ch1 shadow, ch2 capture
    wr(TMR2_CTRL_OFS, 32'h0);
    wr(TMR2_CCMODE_OFS, 32'h39);
    wr(TMR2_CC0_OFS, 32'h10);
    wr(TMR2_CC0_OFS + 6'h04, 32'h20);
    wr(TMR2_PORT_OFS, 32'h2);
    rc(TMR2_PORT_OFS, 32'h20, 32'h20, "shadow");
    wr(TMR2_COUNT_OFS, 32'hC);
    wr(TMR2_CTRL_OFS, 32'h1);
    tick(60);
    chk(32'h1, 32'h1, compare_out, "match set");
    wr(TMR2_PORT_OFS, 32'h2);
    chk(32'h1, 32'h1, compare_out, "write ignored");
    tick(90);
    chk(32'h3, 32'h3, compare_out, "shadow copy");
    rc(TMR2_STAT_OFS, 32'hC, 32'hC, "match events");
    wr(TMR2_COUNT_OFS, 32'hFFFC);
    tick(40);
    chk(32'h2, 32'h2, compare_out, "overflow clear");
    // Capture on ch2
    wr(TMR2_CTRL_OFS, 32'h0);
    wr(TMR2_COUNT_OFS, 32'hABC);
    pins.cap(2);
    rc(TMR2_CC0_OFS + 6'h08, 32'hABC, 32'hABC, "capture");
    rc(TMR2_STAT_OFS, 32'h11, 32'h11, "capture event");
    end_of_test();
  end
endmodule
